// ---- hdl/rsa_defines.svh ----
// Behaviour
// - prescaler code 00 gives modulus 4, 01 gives 8, 10 and 11 give 16
// - integer-mode bit forces integer-only modulation; host then avoids frequency modulation
// - pump tri-state bit at 1 floats both charge pumps, 0 runs them
// - dither bit 0 turns modulator dithering off, 1 turns it on
// - lock window codes 00/11 give 1 cycle, 01 two, 10 three
// - speedup enable applies boost current and speedup count, otherwise both ignored
// - boost pump turns off after count phase-detector periods; host never writes 0
// - every carrier shift write recomputes integer and numerator fed to the modulator
// - gain hold at 1 freezes both stage gains while the loop runs
// - loop lowers gain above upper threshold, raises it below lower threshold
// - lower threshold codes map to -8,-6,-4,-2,0,1,2,3 dB
// - calibration starts on a rising bit edge, lasts 1.3 ms, then clears itself
// - burst tracking uses the fastest step period while outside the threshold window
// - step period code sets how fast each stage gain moves one step
// - first stage step is 1 dB when bit is 0, 2 dB when 1
// - filter width code selects F0 with top bit set, else F1 to F4
// - a pending numerator takes effect only when the integer register is written
// - the numerator is a signed two's-complement value
`ifndef RSA_DEFINES_SVH
`define RSA_DEFINES_SVH

`define RSA_IDX_NUMERATOR 5'h01
`define RSA_IDX_WHOLE     5'h02
`define RSA_IDX_DIVIDER   5'h03
`define RSA_IDX_SPEEDUP   5'h04
`define RSA_IDX_SQUELCH   5'h05
`define RSA_IDX_SHIFT     5'h06
`define RSA_IDX_GAINLOOP  5'h07

`define RSA_RST_NUMERATOR 18'h00000
`define RSA_RST_WHOLE     18'h00000
`define RSA_RST_DIVIDER   18'h00080
`define RSA_RST_SPEEDUP   18'h01000
`define RSA_RST_SQUELCH   18'h00000
`define RSA_RST_SHIFT     18'h00000
`define RSA_RST_GAINLOOP  18'h16241

// divider/lock register fields
`define RSA_DIV_INTMODE   16
`define RSA_DIV_HIZ       15
`define RSA_DIV_DITHER    14
`define RSA_DIV_LDW_HI    13
`define RSA_DIV_LDW_LO    12
`define RSA_DIV_PRE_HI    9
`define RSA_DIV_PRE_LO    8
// speedup register fields
`define RSA_SPD_EN        16
`define RSA_SPD_CUR_HI    15
`define RSA_SPD_CUR_LO    13
`define RSA_SPD_CNT_HI    12
// gain loop register fields
`define RSA_GL_HOLD       17
`define RSA_GL_UPPER_HI   16
`define RSA_GL_UPPER_LO   14
`define RSA_GL_LOWER_HI   13
`define RSA_GL_LOWER_LO   11
`define RSA_GL_CAL        10
`define RSA_GL_BURST      9
`define RSA_GL_PERIOD_HI  8
`define RSA_GL_PERIOD_LO  7
`define RSA_GL_STEP2      6
`define RSA_GL_DISABLE    5
`define RSA_GL_BW_HI      4
`define RSA_GL_BW_LO      2

`define RSA_CLK_MHZ       50
`define RSA_CAL_TIME_US   1300
`define RSA_SWEEP_US_0    600
`define RSA_SWEEP_US_1    67000
`define RSA_SWEEP_US_2    134000
`define RSA_SWEEP_US_3    267000
`define RSA_SWEEP_STEPS   64

`define RSA_RESP_OKAY     2'h0
`define RSA_RESP_SLVERR   2'h2

`endif

// ---- hdl/rsa_pkg.sv ----
package rsa_pkg;

	typedef struct packed {
		logic [4:0]  prescaler_modulus;
		logic        whole_number_mode;
		logic        pump_tristate;
		logic        modulator_noise_spread;
		logic [1:0]  lock_window_cycles;
		logic        lock_detect_type;
		logic [7:0]  reference_divider;
		logic [14:0] mod_integer;
		logic [17:0] mod_numerator;
		logic        boost_pump_on;
		logic [2:0]  boost_pump_current;
	} rsa_synth_s;

	typedef struct packed {
		logic [5:0]  stage1_gain;
		logic [4:0]  stage2_gain;
		logic [4:0]  upper_threshold_db;
		logic [4:0]  lower_threshold_db;
		logic [4:0]  filter_select;
		logic [1:0]  squelch_threshold_select;
		logic        cal_running;
	} rsa_agc_s;

	typedef struct packed {
		logic        pd_tick;
		logic        s1_high;
		logic        s1_low;
		logic        s2_high;
		logic        s2_low;
	} rsa_sense_s;

endpackage

// ---- hdl/rsa_ctrl_regs.sv ----
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rsa_defines.svh"

module rsa_ctrl_regs
	import rsa_pkg::*;
#(
	parameter int CAL_CYCLES   = `RSA_CAL_TIME_US * `RSA_CLK_MHZ,
	parameter int STEP_CYC_0   = `RSA_SWEEP_US_0 * `RSA_CLK_MHZ / `RSA_SWEEP_STEPS,
	parameter int STEP_CYC_1   = `RSA_SWEEP_US_1 * `RSA_CLK_MHZ / `RSA_SWEEP_STEPS,
	parameter int STEP_CYC_2   = `RSA_SWEEP_US_2 * `RSA_CLK_MHZ / `RSA_SWEEP_STEPS,
	parameter int STEP_CYC_3   = `RSA_SWEEP_US_3 * `RSA_CLK_MHZ / `RSA_SWEEP_STEPS
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire rsa_sense_s  sense,
	output rsa_synth_s       synth,
	output rsa_agc_s         agc
);

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_held;
		logic        w_held;
		logic [4:0]  aw_idx;
		logic        aw_bad;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [17:0] numerator_pend;
		logic [17:0] numerator_act;
		logic [17:0] whole;
		logic [17:0] divider;
		logic [17:0] speedup;
		logic [17:0] squelch;
		logic [17:0] shift;
		logic [17:0] gainloop;
		rsa_sense_s  sync1;
		rsa_sense_s  sync2;
		logic        tick_prev;
		logic [12:0] boost_cnt;
		logic [16:0] cal_cnt;
		logic [19:0] step_cnt;
		rsa_synth_s  synth;
		rsa_agc_s    agc;
	} rsa_state_s;

	rsa_state_s st;
	rsa_state_s next_st;

	function automatic logic [17:0] merge(input logic [17:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [17:0] r;
		r = old;
		if (be[0])
			r[7:0] = d[7:0];
		if (be[1])
			r[15:8] = d[15:8];
		if (be[2])
			r[17:16] = d[17:16];
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a[7:2] >= 6'(`RSA_IDX_NUMERATOR)
			&& a[7:2] <= 6'(`RSA_IDX_GAINLOOP);
	endfunction

	function automatic logic [4:0] upper_db(input logic [2:0] c);
		return 5'(signed'({2'h0, c}) - 5'sh05);
	endfunction

	function automatic logic [4:0] lower_db(input logic [2:0] c);
		logic [4:0] r;
		case (c)
			3'h0: r = 5'h18;
			3'h1: r = 5'h1A;
			3'h2: r = 5'h1C;
			3'h3: r = 5'h1E;
			3'h4: r = 5'h00;
			3'h5: r = 5'h01;
			3'h6: r = 5'h02;
			default: r = 5'h03;
		endcase
		return r;
	endfunction

	logic [19:0] step_limit;
	logic [33:0] combined;
	logic        tick_edge;
	logic        s1_out;
	logic        s2_out;
	logic        wr_go;
	logic [17:0] wr_val;
	logic        cal_was;

	always_comb
	begin
		next_st = st;
		step_limit = 20'h00000;
		combined = 34'h000000000;
		wr_val = 18'h00000;
		cal_was = st.gainloop[`RSA_GL_CAL];

		// sense inputs pass two flops before use
		next_st.sync1 = sense;
		next_st.sync2 = st.sync1;
		next_st.tick_prev = st.sync2.pd_tick;
		tick_edge = st.sync2.pd_tick && !st.tick_prev;

		// write address and data taken in either order
		if (s_axi_awvalid && st.awready)
		begin
			next_st.aw_held = 1'b1;
			next_st.awready = 1'b0;
			next_st.aw_idx = s_axi_awaddr[6:2];
			next_st.aw_bad = !mapped(s_axi_awaddr);
		end
		if (s_axi_wvalid && st.wready)
		begin
			next_st.w_held = 1'b1;
			next_st.wready = 1'b0;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		wr_go = st.aw_held && st.w_held && !st.bvalid;
		if (wr_go)
		begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = st.aw_bad ? `RSA_RESP_SLVERR : `RSA_RESP_OKAY;
		end
		if (st.bvalid && s_axi_bready)
		begin
			next_st.bvalid = 1'b0;
			next_st.awready = 1'b1;
			next_st.wready = 1'b1;
		end

		if (wr_go && !st.aw_bad)
		begin
			case (st.aw_idx)
				`RSA_IDX_NUMERATOR:
					next_st.numerator_pend = merge(st.numerator_pend, st.wdata, st.wstrb);
				`RSA_IDX_WHOLE:
				begin
					next_st.whole = merge(st.whole, st.wdata, st.wstrb);
					next_st.numerator_act = st.numerator_pend;
				end
				`RSA_IDX_DIVIDER:
				begin
					wr_val = merge(st.divider, st.wdata, st.wstrb);
					next_st.divider = {1'b0, wr_val[16:0]};
				end
				`RSA_IDX_SPEEDUP:
				begin
					wr_val = merge(st.speedup, st.wdata, st.wstrb);
					next_st.speedup = {1'b0, wr_val[16:0]};
				end
				`RSA_IDX_SQUELCH:
				begin
					wr_val = merge(st.squelch, st.wdata, st.wstrb);
					next_st.squelch = {wr_val[17:16], 16'h0000};
				end
				`RSA_IDX_SHIFT:
					next_st.shift = merge(st.shift, st.wdata, st.wstrb);
				`RSA_IDX_GAINLOOP:
					next_st.gainloop = merge(st.gainloop, st.wdata, st.wstrb);
				default:
					next_st.shift = st.shift;
			endcase
		end

		// read channel
		if (s_axi_arvalid && st.arready)
		begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = mapped(s_axi_araddr) ? `RSA_RESP_OKAY : `RSA_RESP_SLVERR;
			case (mapped(s_axi_araddr) ? s_axi_araddr[6:2] : 5'h00)
				`RSA_IDX_NUMERATOR: next_st.rdata = {14'h0000, st.numerator_pend};
				`RSA_IDX_WHOLE:     next_st.rdata = {14'h0000, st.whole};
				`RSA_IDX_DIVIDER:   next_st.rdata = {14'h0000, st.divider};
				`RSA_IDX_SPEEDUP:   next_st.rdata = {14'h0000, st.speedup};
				`RSA_IDX_SQUELCH:   next_st.rdata = {14'h0000, st.squelch};
				`RSA_IDX_SHIFT:     next_st.rdata = {14'h0000, st.shift};
				`RSA_IDX_GAINLOOP:  next_st.rdata = {14'h0000, st.gainloop};
				default:            next_st.rdata = 32'h00000000;
			endcase
		end
		if (st.rvalid && s_axi_rready)
		begin
			next_st.rvalid = 1'b0;
			next_st.arready = 1'b1;
		end

		// modulator values recomputed from integer, signed numerator and signed shift
		combined = {1'b0, next_st.whole[14:0], 18'h00000}
			+ {{16{next_st.numerator_act[17]}}, next_st.numerator_act}
			+ {{16{next_st.shift[17]}}, next_st.shift};
		if (wr_go && !st.aw_bad
			&& (st.aw_idx == `RSA_IDX_SHIFT || st.aw_idx == `RSA_IDX_WHOLE))
		begin
			next_st.synth.mod_integer = combined[32:18];
			next_st.synth.mod_numerator = combined[17:0];
		end

		// synthesizer decode
		case (st.divider[`RSA_DIV_PRE_HI:`RSA_DIV_PRE_LO])
			2'h0:    next_st.synth.prescaler_modulus = 5'h04;
			2'h1:    next_st.synth.prescaler_modulus = 5'h08;
			default: next_st.synth.prescaler_modulus = 5'h10;
		endcase
		next_st.synth.whole_number_mode = st.divider[`RSA_DIV_INTMODE];
		next_st.synth.pump_tristate = st.divider[`RSA_DIV_HIZ];
		next_st.synth.modulator_noise_spread = st.divider[`RSA_DIV_DITHER];
		case (st.divider[`RSA_DIV_LDW_HI:`RSA_DIV_LDW_LO])
			2'h1:    next_st.synth.lock_window_cycles = 2'h2;
			2'h2:    next_st.synth.lock_window_cycles = 2'h3;
			default: next_st.synth.lock_window_cycles = 2'h1;
		endcase
		next_st.synth.lock_detect_type = st.divider[11];
		next_st.synth.reference_divider = st.divider[7:0];

		// speedup: a new channel written with speedup on arms the boost pump
		if (!st.speedup[`RSA_SPD_EN])
			next_st.boost_cnt = 13'h0000;
		else if (wr_go && !st.aw_bad && st.aw_idx == `RSA_IDX_WHOLE)
			next_st.boost_cnt = st.speedup[`RSA_SPD_CNT_HI:0];
		else if (tick_edge && st.boost_cnt != 13'h0000)
			next_st.boost_cnt = st.boost_cnt - 13'h0001;
		next_st.synth.boost_pump_on = next_st.boost_cnt != 13'h0000;
		next_st.synth.boost_pump_current = st.speedup[`RSA_SPD_EN]
			? st.speedup[`RSA_SPD_CUR_HI:`RSA_SPD_CUR_LO] : 3'h0;

		// calibration: rising edge of the bit starts it, completion clears it
		if (!cal_was && next_st.gainloop[`RSA_GL_CAL])
			next_st.cal_cnt = 17'(CAL_CYCLES);
		else if (cal_was && st.cal_cnt != 17'h00000)
		begin
			next_st.gainloop[`RSA_GL_CAL] = 1'b1;
			next_st.cal_cnt = st.cal_cnt - 17'h00001;
			if (st.cal_cnt == 17'h00001)
				next_st.gainloop[`RSA_GL_CAL] = 1'b0;
		end
		else
			next_st.gainloop[`RSA_GL_CAL] = 1'b0;
		next_st.agc.cal_running = next_st.gainloop[`RSA_GL_CAL];

		// gain loop
		s1_out = st.sync2.s1_high || st.sync2.s1_low;
		s2_out = st.sync2.s2_high || st.sync2.s2_low;
		case ((st.gainloop[`RSA_GL_BURST] && (s1_out || s2_out)) ? 2'h0
			: st.gainloop[`RSA_GL_PERIOD_HI:`RSA_GL_PERIOD_LO])
			2'h0:    step_limit = 20'(STEP_CYC_0);
			2'h1:    step_limit = 20'(STEP_CYC_1);
			2'h2:    step_limit = 20'(STEP_CYC_2);
			default: step_limit = 20'(STEP_CYC_3);
		endcase
		if (st.gainloop[`RSA_GL_DISABLE] || st.gainloop[`RSA_GL_HOLD])
			next_st.step_cnt = 20'h00000;
		else if (st.step_cnt + 20'h00001 < step_limit)
			next_st.step_cnt = st.step_cnt + 20'h00001;
		else
		begin
			next_st.step_cnt = 20'h00000;
			if (st.sync2.s1_high)
				next_st.agc.stage1_gain = (st.agc.stage1_gain > {5'h00, st.gainloop[6]})
					? st.agc.stage1_gain - {4'h0, st.gainloop[6], !st.gainloop[6]}
					: 6'h00;
			else if (st.sync2.s1_low)
				next_st.agc.stage1_gain = (st.agc.stage1_gain < 6'(6'h3F - st.gainloop[6]))
					? st.agc.stage1_gain + {4'h0, st.gainloop[6], !st.gainloop[6]}
					: 6'h3F;
			if (st.sync2.s2_high && st.agc.stage2_gain != 5'h00)
				next_st.agc.stage2_gain = st.agc.stage2_gain - 5'h01;
			else if (st.sync2.s2_low && st.agc.stage2_gain != 5'h1F)
				next_st.agc.stage2_gain = st.agc.stage2_gain + 5'h01;
		end
		next_st.agc.upper_threshold_db =
			upper_db(st.gainloop[`RSA_GL_UPPER_HI:`RSA_GL_UPPER_LO]);
		next_st.agc.lower_threshold_db =
			lower_db(st.gainloop[`RSA_GL_LOWER_HI:`RSA_GL_LOWER_LO]);
		if (st.gainloop[`RSA_GL_BW_HI])
			next_st.agc.filter_select = 5'h01;
		else
			next_st.agc.filter_select = 5'(5'h02 << st.gainloop[3:2]);
		next_st.agc.squelch_threshold_select = st.squelch[17:16];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.awready <= 1'b1;
			st.wready <= 1'b1;
			st.arready <= 1'b1;
			st.numerator_pend <= `RSA_RST_NUMERATOR;
			st.numerator_act <= `RSA_RST_NUMERATOR;
			st.whole <= `RSA_RST_WHOLE;
			st.divider <= `RSA_RST_DIVIDER;
			st.speedup <= `RSA_RST_SPEEDUP;
			st.squelch <= `RSA_RST_SQUELCH;
			st.shift <= `RSA_RST_SHIFT;
			st.gainloop <= `RSA_RST_GAINLOOP;
			st.agc.stage1_gain <= 6'h20;
			st.agc.stage2_gain <= 5'h10;
		end
		else
			st <= next_st;
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign synth = st.synth;
	assign agc = st.agc;

endmodule

// ---- test/rsa_ctrl_regs_sva.sv ----
`timescale 1ns/1ns
module rsa_ctrl_regs_chk
	import rsa_pkg::*;
#(
	parameter int CAL_CYCLES = 20
)
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire rsa_sense_s  sense,
	input wire rsa_agc_s    agc,
	input wire rsa_synth_s  synth
);
	logic [15:0] cal_cnt;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !agc.cal_running)
			cal_cnt <= 16'h0000;
		else
			cal_cnt <= cal_cnt + 16'h0001;
	end
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_over;
		sense.s1_high [*7];
	endsequence
	sequence s_under;
		sense.s1_low [*7];
	endsequence
	chk_write_answer: assert property (s_wr_taken |=> !s_axi_awready ##[0:1] s_axi_bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_read_word: assert property (s_axi_rvalid |-> s_axi_rdata[31:18] == 14'h0000
		&& (s_axi_rresp == 2'h0 || s_axi_rdata == 32'h0))
		else $error("bad read word");
	chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
		else $error("bad write response");
	chk_prescaler_set: assert property (synth.prescaler_modulus inside {5'h0, 5'h4, 5'h8, 5'h10})
		else $error("bad prescaler modulus");
	chk_filter_onehot: assert property ($onehot0(agc.filter_select))
		else $error("filter select not one-hot");
	chk_cal_bound: assert property (cal_cnt <= 16'(CAL_CYCLES + 2))
		else $error("calibration overran");
	chk_gain_pace: assert property ($changed(agc.stage1_gain) |=> $stable(agc.stage1_gain) [*2])
		else $error("gain stepped too fast");
	chk_stage1_step: assert property ($changed(agc.stage1_gain) |->
		(agc.stage1_gain - $past(agc.stage1_gain)) inside {6'h01, 6'h02, 6'h3F, 6'h3E})
		else $error("bad stage1 step");
	chk_no_rise_over: assert property (s_over |-> agc.stage1_gain <= $past(agc.stage1_gain))
		else $error("gain rose above window");
	chk_no_fall_under: assert property (s_under |-> agc.stage1_gain >= $past(agc.stage1_gain))
		else $error("gain fell below window");
endmodule

bind rsa_ctrl_regs rsa_ctrl_regs_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .sense(sense), .agc(agc), .synth(synth));

// ---- test/rsa_host_model.sv ----
`timescale 1ns/1ns
module rsa_host_model
(
	input  wire logic        aclk,
	input  wire logic        go,
	input  wire logic        we,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] data,
	output logic             done,
	output logic [31:0]      rdata,
	output logic [1:0]       resp,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] s_rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, done} = 6'h00;
		{awaddr, araddr, wdata, rdata, resp} = 82'h0;
		wstrb = 4'hF;
	end
	// one transfer at a time; released payload shows the inverse of its last value
	always @(posedge aclk)
	begin
		if (go && we)
		begin
			awaddr <= addr;
			wdata <= data;
			{awvalid, wvalid, bready} <= 3'h7;
		end
		else if (go)
		begin
			araddr <= addr;
			{arvalid, rready} <= 2'h3;
		end
		if (awvalid && awready)
		begin
			awvalid <= 1'b0;
			awaddr <= ~awaddr;
		end
		if (wvalid && wready)
		begin
			wvalid <= 1'b0;
			wdata <= ~wdata;
		end
		if (arvalid && arready)
		begin
			arvalid <= 1'b0;
			araddr <= ~araddr;
		end
		done <= (bvalid && bready) || (rvalid && rready);
		if (bvalid && bready)
		begin
			bready <= 1'b0;
			resp <= bresp;
			rdata <= 32'h0;
		end
		if (rvalid && rready)
		begin
			rready <= 1'b0;
			resp <= rresp;
			rdata <= s_rdata;
		end
	end
endmodule

// ---- test/receiver_synth_agc_control_regs_test.sv ----
`timescale 1ns/1ns
module receiver_synth_agc_control_regs_test;
	import rsa_pkg::*;
	localparam int         CAL = 20;
	localparam logic [17:0] RST [0:6] = '{18'h0, 18'h0, 18'h80, 18'h1000, 18'h0, 18'h0, 18'h16241};
	localparam logic [4:0] LOW [0:7] = '{5'h18, 5'h1A, 5'h1C, 5'h1E, 5'h0, 5'h1, 5'h2, 5'h3};
	logic        aclk, aresetn, go, we, done, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  addr, awaddr, araddr, r1;
	logic [31:0] data, rdata, wdata, s_rdata;
	logic [31:0] lfsr = 32'hF47C499F;
	logic [3:0]  wstrb;
	logic [1:0]  resp, bresp, rresp;
	logic [17:0] v;
	logic [5:0]  g1, d;
	logic [65:0] e;
	logic [65:0] exp_q [$];
	rsa_sense_s  sense;
	rsa_synth_s  synth;
	rsa_agc_s    agc;
	int          errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	rsa_ctrl_regs #(.CAL_CYCLES(CAL), .STEP_CYC_0(3), .STEP_CYC_1(5), .STEP_CYC_2(7),
		.STEP_CYC_3(9)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(s_rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense(sense),
		.synth(synth), .agc(agc));
	rsa_host_model u_host (.aclk(aclk), .go(go), .we(we), .addr(addr), .data(data), .done(done),
		.rdata(rdata), .resp(resp), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .s_rdata(s_rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic xfer(input logic w, input logic [4:0] idx, input logic [31:0] dv,
		input logic [31:0] m, input logic [1:0] r);
		int n;
		n = 0;
		exp_q.push_back({m, dv, r});
		@(posedge aclk);
		go <= 1'b1;
		we <= w;
		addr <= {1'b0, idx, 2'b00};
		data <= dv;
		@(posedge aclk);
		go <= 1'b0;
		while (done !== 1'b1 && n < 40)
		begin
			@(posedge aclk);
			n++;
		end
		check(n < 40, "no answer");
		#1;
	endtask
	task automatic wr(input logic [4:0] idx, input logic [31:0] dv);
		xfer(1'b1, idx, dv, 32'h0, 2'h0);
	endtask
	task automatic pulse(input int n);
		repeat (n)
		begin
			sense.pd_tick <= 1'b1;
			tick(3);
			sense.pd_tick <= 1'b0;
			tick(3);
		end
	endtask
	function automatic logic [31:0] gval(input logic h, input logic [1:0] p, input logic b,
		input logic s);
		return {14'h0, h, 3'h5, 3'h4, 1'b0, b, p, s, 1'b0, 3'h0, 2'h1};
	endfunction
	always @(posedge aclk)
	begin
		cyc++;
		if (done === 1'b1)
		begin
			e = exp_q.pop_front();
			check(resp === e[1:0] && (rdata & e[65:34]) === (e[33:2] & e[65:34]), "bus answer");
		end
		if (cyc == 6000)
		begin
			check(1'b0, "timeout");
			wrap_up();
		end
	end
	initial
	begin
		{aresetn, go, we, addr, data} = '0;
		sense = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			xfer(1'b0, 5'(i + 1), {14'h0, RST[i]}, 32'h3FFFF, 2'h0);
		check(synth.prescaler_modulus === 5'h4 && agc.filter_select === 5'h2, "reset decode");
		xfer(1'b0, 5'h1F, 32'h0, 32'hFFFFFFFF, 2'h2);
		xfer(1'b1, 5'h1F, 32'h3FFFF, 32'h0, 2'h2);
		$display("reset and map test done");
		for (int i = 0; i < 4; i++)
		begin
			lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
			r1 = 8'(7 + lfsr[7:0] % 249);
			v = {1'b0, i == 2, i[0], i == 1, i[1:0], i[0], 1'b0, i[1:0], r1};
			wr(5'h03, {14'h0, v});
			xfer(1'b0, 5'h03, {14'h0, v}, 32'h3FFFF, 2'h0);
			check(synth.prescaler_modulus === (i == 0 ? 5'h4 : i == 1 ? 5'h8 : 5'h10), "pre");
			check(synth.lock_window_cycles === (i == 1 ? 2'h2 : i == 2 ? 2'h3 : 2'h1), "win");
			check({synth.whole_number_mode, synth.pump_tristate, synth.modulator_noise_spread}
				=== v[16:14], "mode bits");
			check(synth.reference_divider === r1 && synth.lock_detect_type === v[11], "div");
		end
		$display("divider test done");
		wr(5'h01, 32'h3FFFF);
		check({synth.mod_integer, synth.mod_numerator} === 33'h0, "staged");
		wr(5'h02, 32'h190);
		check({synth.mod_integer, synth.mod_numerator} === 33'h63FFFFF, "frac");
		wr(5'h06, 32'h5);
		check({synth.mod_integer, synth.mod_numerator} === 33'h6400004, "shift");
		wr(5'h06, 32'h0);
		check({synth.mod_integer, synth.mod_numerator} === 33'h63FFFFF, "unshift");
		$display("fraction test done");
		wr(5'h04, 32'h1A003);
		wr(5'h02, 32'h190);
		check(synth.boost_pump_on === 1'b1 && synth.boost_pump_current === 3'h5, "on");
		pulse(2);
		check(synth.boost_pump_on === 1'b1, "boost early");
		pulse(1);
		tick(4);
		check(synth.boost_pump_on === 1'b0, "boost late");
		wr(5'h04, 32'h0A003);
		check(synth.boost_pump_current === 3'h0, "boost gated");
		$display("speedup test done");
		for (int k = 0; k < 8; k++)
		begin
			v = {1'b0, k[2:0], k[2:0], 4'h0, 2'h3, k[2:0], 2'h1};
			wr(5'h07, {14'h0, v});
			xfer(1'b0, 5'h07, {14'h0, v}, 32'h3FFFC, 2'h0);
			check(agc.lower_threshold_db === LOW[k], "lower");
			check(agc.upper_threshold_db === 5'(k - 5), "upper");
			check(agc.filter_select === (k > 3 ? 5'h1 : 5'h2 << k), "filter");
		end
		$display("field table test done");
		sense.s1_low <= 1'b1;
		wr(5'h07, gval(1'b0, 2'h0, 1'b0, 1'b1));
		tick(20);
		check(agc.stage1_gain > 6'h20 && agc.stage1_gain[0] === 1'b0, "rise");
		wr(5'h07, gval(1'b1, 2'h0, 1'b0, 1'b1));
		tick(2);
		g1 = agc.stage1_gain;
		tick(20);
		check(agc.stage1_gain === g1, "held");
		sense.s1_low <= 1'b0;
		sense.s1_high <= 1'b1;
		for (int b = 0; b < 2; b++)
		begin
			wr(5'h07, gval(1'b0, 2'h3, b[0], 1'b0));
			tick(4);
			g1 = agc.stage1_gain;
			tick(36);
			d = g1 - agc.stage1_gain;
			check(b == 0 ? d >= 6'h3 && d <= 6'h5 : d >= 6'hA, "pace");
		end
		sense.s1_high <= 1'b0;
		$display("gain loop test done");
		wr(5'h07, gval(1'b0, 2'h0, 1'b0, 1'b1) | 32'h400);
		check(agc.cal_running === 1'b1, "cal run");
		xfer(1'b0, 5'h07, 32'h400, 32'h400, 2'h0);
		tick(CAL + 5);
		xfer(1'b0, 5'h07, 32'h0, 32'h400, 2'h0);
		check(agc.cal_running === 1'b0, "cal end");
		$display("calibration test done");
		wrap_up();
	end
endmodule
